// file: dbr_pkg.sv
// Notes on behaviour
// (R01) Four-bit debug response control register, loaded by its JTAG instruction, resets to zero.
// (R02) With enable bit clear, event and cycle counters handle core debug events normally.
// (R03) With enable bit set, low 32 cycle counter bits form the reset countdown.
// (R04) Reset countdown decrements each cycle after the flush-stop acknowledge rises.
// (R05) With enable bit set, the debug event counter is ignored entirely.
// (R06) Value 100: one watchpoint pulse when the reset countdown reaches zero.
// (R07) Value 101: hard clock stop plus one watchpoint at reset countdown zero.
// (R08) Value 110: clock stretch pulse plus one watchpoint at reset countdown zero.
// (R09) Value 111: stretch and watchpoint, then upper half counts, hard stop and watchpoint.
// (R10) Soft-stop bit set and any cluster soft request soft-stops all enabled clusters.
// (R11) Driver should set soft-stop bit only while the enable bit is clear.
// (R12) Driver should clear bits 3 and 2 before JTAG clock stop access.
// (R13) Forward a watchpoint request only when both counters are zero, and only once.
// (R14) For clock stop use, the watchpoint pulse comes from the debug event itself.
// (R15) Rewriting the event counter non-zero re-arms forwarding of one more request.
// (R16) Clock restart instruction then test-logic-reset re-arms watchpoint forwarding.
// (R17) While clock restart stays active in run-test-idle, every request is forwarded; after a cycle counter delay the code forwards only if armed.
// (R18) The 64-bit cycle counter counts down each cycle to delay the debug response.
// (R19) Non-zero event counter decrements per request; cycle counter starts on next request.
// (R20) Each watchpoint pulse lasts exactly one io clock cycle.
// (R21) Reset countdown holds at zero so each action fires once per reset.
package dbr_pkg;
    localparam int DBR_CTRL_W = 4;
    localparam logic [3:0] DBR_CTRL_RST = 4'h0;
    localparam int DBR_BIT_SOFT = 3;
    localparam int DBR_BIT_EN = 2;
    localparam logic [1:0] DBR_MODE_WP = 2'h0;
    localparam logic [1:0] DBR_MODE_HARD = 2'h1;
    localparam logic [1:0] DBR_MODE_STR = 2'h2;
    localparam logic [1:0] DBR_MODE_STR_HARD = 2'h3;
    localparam logic [63:0] DBR_CYC_RST = 64'h0000_0000_0000_0000;
    localparam logic [31:0] DBR_EVT_RST = 32'h0000_0000;
    typedef enum logic [2:0]
    {
        DBR_IDLE = 3'b000,
        DBR_LOW = 3'b001,
        DBR_HIGH = 3'b010,
        DBR_DONE = 3'b011,
        DBR_DELAY = 3'b100
    } dbr_state_type;
endpackage

// file: dbr_debug_response.sv
module dbr_debug_response
    import dbr_pkg::*;
#(
    parameter int CLUSTERS = 8
)
(
    input wire logic CLK,
    input wire logic RST,
    input wire logic CTRL_LOAD,
    input wire logic [3:0] CTRL_DATA,
    input wire logic CYC_LOAD,
    input wire logic [63:0] CYC_DATA,
    input wire logic EVT_LOAD,
    input wire logic [31:0] EVT_DATA,
    input wire logic FLUSH_STOP_ACK,
    input wire logic [CLUSTERS-1:0] SOFT_REQ,
    input wire logic [CLUSTERS-1:0] HARD_REQ,
    input wire logic [CLUSTERS-1:0] CORE_TRIG_REQ,
    input wire logic [CLUSTERS-1:0] CLUSTER_EN,
    input wire logic UNCORE_TRIG_REQ,
    input wire logic CLK_RESTART_ACTIVE,
    input wire logic TAP_TLR,
    input wire logic IO_CLK_EN,
    output logic [3:0] CTRL_Q,
    output logic [63:0] CYC_Q,
    output logic [31:0] EVT_Q,
    output logic WATCHPOINT,
    output logic HARD_STOP,
    output logic STRETCH,
    output logic [CLUSTERS-1:0] SOFT_STOP
);
    // ****************************************************************
    // Input synchronisation
    // ****************************************************************
    // Flush ack comes from the reset sequencer domain: three flops, count on agreement
    logic [2:0] ack_sync_r;
    logic [2:0] ack_sync_nxt;
    logic ack_lvl_r;
    logic ack_lvl_nxt;
    logic ack_rise;

    always_comb
    begin
        ack_sync_nxt = {ack_sync_r[1:0], FLUSH_STOP_ACK};
        ack_lvl_nxt = ack_lvl_r;
        if (ack_sync_r[1] == ack_sync_r[2])
        begin
            ack_lvl_nxt = ack_sync_r[2];
        end
    end
    assign ack_rise = ack_lvl_nxt && !ack_lvl_r;

    // ****************************************************************
    // Registers and counters
    // ****************************************************************
    logic [3:0] ctrl_r;
    logic [3:0] ctrl_nxt;
    logic [63:0] cyc_r;
    logic [63:0] cyc_nxt;
    logic [31:0] evt_r;
    logic [31:0] evt_nxt;
    dbr_state_type st_r;
    dbr_state_type st_nxt;
    logic armed_r;
    logic armed_nxt;
    logic restart_seen_r;
    logic restart_seen_nxt;
    logic wp_pend_r;
    logic wp_pend_nxt;
    logic wp_r;
    logic wp_nxt;
    logic hard_r;
    logic hard_nxt;
    logic str_r;
    logic str_nxt;
    logic [CLUSTERS-1:0] soft_r;
    logic [CLUSTERS-1:0] soft_nxt;
    logic [CLUSTERS-1:0] soft_pend_r;
    logic [CLUSTERS-1:0] soft_pend_nxt;
    logic delay_hard_r;
    logic delay_hard_nxt;
    logic delay_trig_r;
    logic delay_trig_nxt;

    logic enable;
    logic any_soft;
    logic any_hard;
    logic trig_req;
    logic any_evt;
    logic fire_wp;

    assign enable = ctrl_r[DBR_BIT_EN];
    assign any_soft = |SOFT_REQ;
    assign any_hard = |HARD_REQ;
    assign trig_req = (|CORE_TRIG_REQ) || UNCORE_TRIG_REQ;
    assign any_evt = any_soft || any_hard || trig_req;

    always_comb
    begin
        ctrl_nxt = ctrl_r;
        cyc_nxt = cyc_r;
        evt_nxt = evt_r;
        st_nxt = st_r;
        armed_nxt = armed_r;
        restart_seen_nxt = restart_seen_r;
        hard_nxt = 1'b0;
        str_nxt = 1'b0;
        soft_nxt = soft_r;
        soft_pend_nxt = soft_pend_r;
        delay_hard_nxt = delay_hard_r;
        delay_trig_nxt = delay_trig_r;
        fire_wp = 1'b0;
        if (CTRL_LOAD)
        begin
            ctrl_nxt = CTRL_DATA; // R01
        end
        if (CYC_LOAD)
        begin
            cyc_nxt = CYC_DATA;
        end
        if (EVT_LOAD)
        begin
            evt_nxt = EVT_DATA;
            if (EVT_DATA != DBR_EVT_RST)
            begin
                armed_nxt = 1'b1; // R15
            end
        end
        if (CLK_RESTART_ACTIVE)
        begin
            restart_seen_nxt = 1'b1;
        end
        if (restart_seen_r && TAP_TLR)
        begin
            armed_nxt = 1'b1; // R16
            restart_seen_nxt = 1'b0;
        end
        if (enable)
        begin
            // Event counter untouched here, so its value survives a mode switch
            unique case (st_r) // R05
                DBR_IDLE:
                begin
                    if (ack_rise)
                    begin
                        st_nxt = DBR_LOW; // R04
                    end
                end
                DBR_LOW:
                begin
                    if (cyc_r[31:0] == 32'h0000_0000)
                    begin
                        fire_wp = 1'b1; // R06
                        hard_nxt = (ctrl_r[1:0] == DBR_MODE_HARD); // R07
                        str_nxt = ctrl_r[1]; // R08
                        st_nxt = (ctrl_r[1:0] == DBR_MODE_STR_HARD) ? DBR_HIGH : DBR_DONE; // R09
                    end
                    else
                    begin
                        cyc_nxt[31:0] = cyc_r[31:0] - 32'h0000_0001; // R03
                    end
                end
                DBR_HIGH:
                begin
                    if (cyc_r[63:32] == 32'h0000_0000)
                    begin
                        fire_wp = 1'b1; // R09
                        hard_nxt = 1'b1; // R09
                        st_nxt = DBR_DONE;
                    end
                    else
                    begin
                        cyc_nxt[63:32] = cyc_r[63:32] - 32'h0000_0001; // R09
                    end
                end
                DBR_DONE:
                begin
                    st_nxt = DBR_DONE; // R21
                end
                DBR_DELAY:
                begin
                    st_nxt = DBR_IDLE;
                end
                default:
                begin
                    st_nxt = DBR_IDLE;
                end
            endcase
        end
        else
        begin
            // Normal mode: event counter, then cycle counter delay
            if (st_r == DBR_DELAY)
            begin
                if (cyc_r == DBR_CYC_RST)
                begin
                    hard_nxt = delay_hard_r;
                    soft_nxt = soft_r | soft_pend_r; // R10
                    if (delay_trig_r && armed_r)
                    begin
                        fire_wp = 1'b1; // R14
                    end
                    st_nxt = DBR_IDLE;
                end
                else
                begin
                    cyc_nxt = cyc_r - 64'h0000_0000_0000_0001; // R18
                end
            end
            else if (any_evt)
            begin
                if (evt_r != DBR_EVT_RST)
                begin
                    evt_nxt = evt_r - 32'h0000_0001; // R19
                end
                else if (cyc_r != DBR_CYC_RST)
                begin
                    st_nxt = DBR_DELAY; // R02
                    delay_hard_nxt = any_hard;
                    delay_trig_nxt = trig_req || any_hard || any_soft;
                    soft_pend_nxt = ctrl_r[DBR_BIT_SOFT] ? CLUSTER_EN : (SOFT_REQ & CLUSTER_EN);
                end
                else
                begin
                    hard_nxt = any_hard;
                    // Soft stop is sticky until reset, so a later request never clears it
                    soft_nxt = soft_r | (ctrl_r[DBR_BIT_SOFT] && any_soft ? CLUSTER_EN : (SOFT_REQ & CLUSTER_EN)); // R10
                    if (armed_r || CLK_RESTART_ACTIVE) // R17
                    begin
                        fire_wp = 1'b1; // R13
                    end
                end
            end
            else if (st_r != DBR_IDLE)
            begin
                st_nxt = DBR_IDLE;
            end
        end
        // A re-arm in the same cycle as a forward wins, so that request is not lost
        if (fire_wp && !CLK_RESTART_ACTIVE && !(EVT_LOAD && EVT_DATA != DBR_EVT_RST) && !(restart_seen_r && TAP_TLR))
        begin
            armed_nxt = 1'b0; // R13
        end
    end

    // ****************************************************************
    // Watchpoint pulse, one io clock wide
    // ****************************************************************
    // Held pending until an io clock enable, then driven for that one io cycle
    always_comb
    begin
        wp_pend_nxt = wp_pend_r;
        wp_nxt = wp_r;
        if (IO_CLK_EN)
        begin
            wp_nxt = wp_pend_r || fire_wp; // R20
            wp_pend_nxt = 1'b0;
        end
        else if (fire_wp)
        begin
            wp_pend_nxt = 1'b1;
        end
    end

    always_ff @(posedge CLK)
    begin
        if (RST)
        begin
            ack_sync_r <= 3'h0;
            ack_lvl_r <= 1'b0;
            ctrl_r <= DBR_CTRL_RST;
            cyc_r <= DBR_CYC_RST;
            evt_r <= DBR_EVT_RST;
            st_r <= DBR_IDLE;
            armed_r <= 1'b1;
            restart_seen_r <= 1'b0;
            wp_pend_r <= 1'b0;
            wp_r <= 1'b0;
            hard_r <= 1'b0;
            str_r <= 1'b0;
            soft_r <= '0;
            soft_pend_r <= '0;
            delay_hard_r <= 1'b0;
            delay_trig_r <= 1'b0;
        end
        else
        begin
            ack_sync_r <= ack_sync_nxt;
            ack_lvl_r <= ack_lvl_nxt;
            ctrl_r <= ctrl_nxt;
            cyc_r <= cyc_nxt;
            evt_r <= evt_nxt;
            st_r <= st_nxt;
            armed_r <= armed_nxt;
            restart_seen_r <= restart_seen_nxt;
            wp_pend_r <= wp_pend_nxt;
            wp_r <= wp_nxt;
            hard_r <= hard_nxt;
            str_r <= str_nxt;
            soft_r <= soft_nxt;
            soft_pend_r <= soft_pend_nxt;
            delay_hard_r <= delay_hard_nxt;
            delay_trig_r <= delay_trig_nxt;
        end
    end

    assign CTRL_Q = ctrl_r;
    assign CYC_Q = cyc_r;
    assign EVT_Q = evt_r;
    assign WATCHPOINT = wp_r;
    assign HARD_STOP = hard_r;
    assign STRETCH = str_r;
    assign SOFT_STOP = soft_r;

    // ****************************************************************
    // Checks
    // ****************************************************************
    default clocking cb @(posedge CLK); endclocking
    default disable iff (RST);

    a_ctrl_load_value: assert property (CTRL_LOAD |=> ctrl_r == $past(CTRL_DATA)) else $error("ctrl not loaded"); // R01
    a_low_count_down: assert property (enable && st_r == DBR_LOW && cyc_r[31:0] != 32'h0 && !CYC_LOAD && !CTRL_LOAD
        |=> cyc_r[31:0] == $past(cyc_r[31:0]) - 32'h1) else $error("low count wrong"); // R03
    a_start_on_ack: assert property (enable && st_r == DBR_IDLE && ack_rise && !CTRL_LOAD |=> st_r == DBR_LOW)
        else $error("countdown not started"); // R04
    a_evt_ignored: assert property (enable && !EVT_LOAD |=> evt_r == $past(evt_r)) else $error("evt moved"); // R05
    a_hard_on_zero: assert property (enable && st_r == DBR_LOW && cyc_r[31:0] == 32'h0 && ctrl_r[1:0] == DBR_MODE_HARD
        |=> hard_r && !str_r) else $error("hard stop missing"); // R07
    a_stretch_on_zero: assert property (enable && st_r == DBR_LOW && cyc_r[31:0] == 32'h0 && ctrl_r[1]
        |=> str_r ##1 !str_r) else $error("stretch not one pulse"); // R08
    a_done_holds: assert property (enable && st_r == DBR_DONE && !CTRL_LOAD |=> st_r == DBR_DONE && !hard_r)
        else $error("done not held"); // R21
    a_evt_decrement: assert property (!enable && st_r != DBR_DELAY && any_evt && evt_r != 32'h0 && !EVT_LOAD
        |=> evt_r == $past(evt_r) - 32'h1) else $error("evt not decremented"); // R19
    a_wp_single: assert property (wp_r && IO_CLK_EN && !wp_pend_r && !fire_wp |=> !wp_r)
        else $error("watchpoint too long"); // R20
    a_fwd_once: assert property (fire_wp && !CLK_RESTART_ACTIVE && !EVT_LOAD && !TAP_TLR |=> !armed_r)
        else $error("not disarmed"); // R13
endmodule

// file: dbr_far_side.sv
module dbr_far_side
#(
    parameter int IO_DIV = 4
)
(
    input wire logic CLK,
    output logic IO_CLK_EN,
    output logic [7:0] SOFT_REQ,
    output logic [7:0] HARD_REQ,
    output logic [7:0] CORE_TRIG_REQ,
    output logic UNCORE_TRIG_REQ
);
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Clusters, uncore and io strobe
    // ****
    int div = 0;
    initial
    begin
        IO_CLK_EN = 1'b0;
        SOFT_REQ = '0;
        HARD_REQ = '0;
        CORE_TRIG_REQ = '0;
        UNCORE_TRIG_REQ = 1'b0;
    end
    // Io clock runs free, so the strobe never pauses
    always @(negedge CLK)
    begin
        div = (div + 1) % IO_DIV;
        IO_CLK_EN <= (div == 0);
    end
    // Kind 0 soft, 1 hard, 2 core trigger, 3 uncore trigger
    task automatic pulse(input int kind, input int idx);
        @(negedge CLK);
        SOFT_REQ[idx] <= (kind == 0);
        HARD_REQ[idx] <= (kind == 1);
        CORE_TRIG_REQ[idx] <= (kind == 2);
        UNCORE_TRIG_REQ <= (kind == 3);
        @(negedge CLK);
        SOFT_REQ <= '0;
        HARD_REQ <= '0;
        CORE_TRIG_REQ <= '0;
        UNCORE_TRIG_REQ <= 1'b0;
    endtask
endmodule

// file: dbr_debug_response_test.sv
module dbr_debug_response_test;
    timeunit 1ns;
    timeprecision 100ps;
    // ****
    // Signals, clock and monitors
    // ****
    localparam int IO_DIV = 4;
    logic clk = 0;
    logic rst = 1;
    logic ctrl_load = 0;
    logic cyc_load = 0;
    logic evt_load = 0;
    logic ack = 0;
    logic restart = 0;
    logic tlr = 0;
    logic [3:0] ctrl_data = '0;
    logic [63:0] cyc_data = '0;
    logic [31:0] evt_data = '0;
    logic [7:0] clu_en = 8'hFF;
    logic io_en, unc_req, wp, hs, st;
    logic [7:0] soft_req, hard_req, core_req, soft_stop;
    logic [3:0] ctrl_q;
    logic [63:0] cyc_q;
    logic [31:0] evt_q;
    int failures = 0;
    int checks = 0;
    int wp_cnt = 0;
    int hs_cnt = 0;
    int st_cnt = 0;
    int wp_len = 0;
    always #12.5 clk = ~clk;
    dbr_far_side #(.IO_DIV(IO_DIV)) far_u (.CLK(clk), .IO_CLK_EN(io_en), .SOFT_REQ(soft_req),
        .HARD_REQ(hard_req), .CORE_TRIG_REQ(core_req), .UNCORE_TRIG_REQ(unc_req));
    dbr_debug_response #(.CLUSTERS(8)) dut_u (.CLK(clk), .RST(rst), .CTRL_LOAD(ctrl_load),
        .CTRL_DATA(ctrl_data), .CYC_LOAD(cyc_load), .CYC_DATA(cyc_data), .EVT_LOAD(evt_load),
        .EVT_DATA(evt_data), .FLUSH_STOP_ACK(ack), .SOFT_REQ(soft_req), .HARD_REQ(hard_req),
        .CORE_TRIG_REQ(core_req), .CLUSTER_EN(clu_en), .UNCORE_TRIG_REQ(unc_req),
        .CLK_RESTART_ACTIVE(restart), .TAP_TLR(tlr), .IO_CLK_EN(io_en), .CTRL_Q(ctrl_q),
        .CYC_Q(cyc_q), .EVT_Q(evt_q), .WATCHPOINT(wp), .HARD_STOP(hs), .STRETCH(st),
        .SOFT_STOP(soft_stop));
    // Counting high cycles also proves the one-cycle width of stop and stretch
    always @(posedge clk)
    begin
        hs_cnt += (hs === 1'b1);
        st_cnt += (st === 1'b1);
        if (wp === 1'b1)
        begin
            wp_cnt += (wp_len == 0);
            wp_len++;
        end
        else if (wp_len > 0)
        begin
            chk_cnt(wp_len, IO_DIV);
            wp_len = 0;
        end
    end
    // ****
    // Shared tasks
    // ****
    task chk_val(input logic [63:0] got, input logic [63:0] exp);
        checks++;
        if (got !== exp)
        begin
            failures++;
            $display("BAD %0t value %h expected %h", $time, got, exp);
        end
    endtask
    task chk_cnt(input int got, input int exp);
        checks++;
        if (got != exp)
        begin
            failures++;
            $display("BAD %0t count %0d expected %0d", $time, got, exp);
        end
    endtask
    task cyc(input int n);
        repeat (n) @(negedge clk);
    endtask
    task do_reset;
        @(negedge clk);
        rst <= 1;
        ack <= 0;
        restart <= 0;
        tlr <= 0;
        clu_en <= 8'hFF;
        cyc(3);
        rst <= 0;
        wp_cnt = 0;
        hs_cnt = 0;
        st_cnt = 0;
        wp_len = 0;
    endtask
    // Sel 0 control, 1 cycle counter, 2 event counter
    task ld(input int sel, input logic [63:0] v);
        @(negedge clk);
        ctrl_data <= v[3:0];
        cyc_data <= v;
        evt_data <= v[31:0];
        ctrl_load <= (sel == 0);
        cyc_load <= (sel == 1);
        evt_load <= (sel == 2);
        @(negedge clk);
        ctrl_load <= 0;
        cyc_load <= 0;
        evt_load <= 0;
    endtask
    task stop_test;
        $display("failures %0d checks %0d", failures, checks);
        if (failures == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    // ****
    // Scenarios
    // ****
    task t_reset;
        do_reset;
        chk_val(ctrl_q, 64'h0);
        chk_val(cyc_q, 64'h0);
        chk_val(evt_q, 64'h0);
        chk_val({wp, hs, st, soft_stop}, 64'h0);
    endtask
    task t_watch;
        do_reset;
        far_u.pulse(2, 3);
        cyc(20);
        chk_cnt(wp_cnt, 1);
        far_u.pulse(3, 0);
        cyc(20);
        chk_cnt(wp_cnt, 1);
        ld(2, 64'h1);
        for (int i = 0; i < 3; i++)
        begin
            far_u.pulse(2, i);
            cyc(20);
        end
        chk_cnt(wp_cnt, 2);
        restart <= 1;
        far_u.pulse(3, 0);
        cyc(20);
        far_u.pulse(2, 4);
        cyc(20);
        chk_cnt(wp_cnt, 4);
        tlr <= 1;
        cyc(2);
        tlr <= 0;
        restart <= 0;
        for (int i = 0; i < 2; i++)
        begin
            far_u.pulse(2, 6);
            cyc(20);
        end
        chk_cnt(wp_cnt, 5);
    endtask
    task t_delay;
        do_reset;
        ld(0, 64'h3);
        ld(1, 64'h28);
        ld(2, 64'h2);
        far_u.pulse(1, 2);
        cyc(3);
        chk_val(evt_q, 64'h1);
        far_u.pulse(1, 5);
        cyc(3);
        chk_val(evt_q, 64'h0);
        chk_cnt(hs_cnt, 0);
        far_u.pulse(1, 5);
        cyc(30);
        chk_cnt(hs_cnt, 0);
        cyc(30);
        chk_cnt(hs_cnt, 1);
        chk_cnt(wp_cnt, 1);
        chk_val(cyc_q, 64'h0);
    endtask
    task t_count(input logic [1:0] mode, input int nwp, input int nhs, input int nst);
        do_reset;
        ld(1, 64'h0000_001E_0000_0014);
        ld(2, 64'h5);
        ld(0, {60'h0, 2'b01, mode});
        chk_val(ctrl_q, {60'h0, 2'b01, mode});
        ack <= 1;
        far_u.pulse(1, 0);
        cyc(18);
        chk_cnt(wp_cnt + hs_cnt + st_cnt, 0);
        cyc(150);
        chk_cnt(wp_cnt, nwp);
        chk_cnt(hs_cnt, nhs);
        chk_cnt(st_cnt, nst);
        chk_val(evt_q, 64'h5);
        chk_val(cyc_q, (mode == 2'h3) ? 64'h0 : 64'h0000_001E_0000_0000);
    endtask
    task t_soft;
        do_reset;
        clu_en <= 8'h0F;
        ld(0, 64'h8);
        far_u.pulse(0, 1);
        cyc(6);
        chk_val(soft_stop, 64'hF);
        ld(0, 64'h0);
    endtask
    initial
    begin
        t_reset;
        t_watch;
        t_delay;
        t_count(2'h0, 1, 0, 0);
        t_count(2'h1, 1, 1, 0);
        t_count(2'h2, 1, 0, 1);
        t_count(2'h3, 2, 1, 1);
        t_soft;
        stop_test;
    end
    // The whole run needs about 1000 cycles
    initial
    begin
        repeat (20000) @(posedge clk);
        failures++;
        stop_test;
    end
endmodule
